// file: src/pbc_pkg.sv
package pbc_pkg;

   // Blanking delay field width and the largest programmable delay.
   localparam int BLANK_DELAY_WIDTH = 12;
   localparam logic [11:0] BLANK_DELAY_MAX = 12'hfff;
   // Field positions inside the blanking control word.
   localparam int LEB_HIGH_RISE_BIT = 0;
   localparam int LEB_HIGH_FALL_BIT = 1;
   localparam int LEB_LOW_RISE_BIT = 2;
   localparam int LEB_LOW_FALL_BIT = 3;
   // Field positions inside the chop divider word.
   localparam int CARRIER_ENABLE_BIT = 15;
   localparam int CARRIER_RATIO_WIDTH = 10;
   // Field positions inside the output control word.
   localparam int OUT_SYNC_BIT = 0;
   localparam int OUT_SWAP_BIT = 1;
   // Source select codes.
   localparam logic [3:0] CARRIER_SRC_INTERNAL = 4'h0;
   localparam logic [2:0] BLANK_SRC_NONE = 3'h0;
   // Reset values.
   localparam logic [11:0] BLANK_COUNT_RESET = 12'h000;
   localparam logic [15:0] CAPTURE_RESET = 16'h0000;
   localparam logic [9:0] CARRIER_COUNT_RESET = 10'h000;
   localparam logic [2:0] PRESCALE_COUNT_RESET = 3'h0;
   // System clock period in nanoseconds and the blanking tick in cycles.
   localparam int SYS_CLK_PERIOD_NS = 25;
   localparam int TOSC_NS = 25;
   localparam int BLANK_TICK_CYCLES = (TOSC_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

endpackage

// file: src/pbc_carrier_if.sv
`timescale 1ns/1ps
interface pbc_carrier_if;
   logic enable;
   logic [9:0] ratio;
   logic [2:0] prescale;
   logic carrier;

   modport gen (input enable, input ratio, input prescale, output carrier);
   modport user (output enable, output ratio, output prescale, input carrier);
endinterface

// file: src/pbc_carrier_gen.sv
`timescale 1ns/1ps
module pbc_carrier_gen
   import pbc_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Control and carrier out.
   pbc_carrier_if.gen cif
);

   logic [7:0] pre_count;
   logic [7:0] next_pre_count;
   logic [9:0] div_count;
   logic [9:0] next_div_count;
   logic carrier;
   logic next_carrier;
   logic pwm_tick;

   // Prescaler makes a one-cycle tick at the divided PWM clock rate; the ratio
   // then counts ticks and toggles the carrier, so a zero ratio toggles each tick.
   always_comb begin
      next_pre_count = pre_count;
      next_div_count = div_count;
      next_carrier = carrier;
      pwm_tick = (pre_count == ((8'h01 << cif.prescale) - 8'h01));
      if (!cif.enable) begin
         next_pre_count = 8'h00;
         next_div_count = CARRIER_COUNT_RESET;
         next_carrier = 1'b0;
      end else begin
         next_pre_count = pwm_tick ? 8'h00 : pre_count + 8'h01;
         if (pwm_tick) begin
            if (div_count >= cif.ratio) begin
               next_div_count = CARRIER_COUNT_RESET;
               next_carrier = ~carrier;
            end else begin
               next_div_count = div_count + 10'h001;
            end
         end
      end
   end

   // State registers.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pre_count <= 8'h00;
         div_count <= CARRIER_COUNT_RESET;
         carrier <= 1'b0;
      end else begin
         pre_count <= next_pre_count;
         div_count <= next_div_count;
         carrier <= next_carrier;
      end
   end

   assign cif.carrier = carrier;

   // The carrier is low from the first clock edge after the generator is switched off.
   a_carrier_off_low: assert property (@(posedge clk) disable iff (!nrst)
      !cif.enable ##1 !cif.enable |-> !carrier)
      else $error("Carrier toggled while disabled.");

endmodule

// file: src/pbc_top.sv
`timescale 1ns/1ps
// Function
// - After selected output edges, ignore chosen fault and limit for 0..4095 periods.
// - Blanking length equals the 12-bit delay value times the system period.
// - Four edge bits choose which high/low rise/fall edges start blanking.
// - A new selected edge during blanking restarts the timer from the start.
// - Separate enables apply blanking to the fault and to the limit input.
// - State bits let output and carrier levels blank the fault and/or limit.
// - A source select may pick another generator's output as state blanking.
// - Chopping ANDs each enabled output with the carrier.
// - The carrier divides the prescaled PWM clock by 2 x (chop ratio + 1).
// - Chop word bit 15 enables the carrier generator; clear keeps it stopped.
// - Separate high and low chop enables gate each output with the carrier.
// - A 4-bit select picks the carrier: internal by default, codes 1..PEER_COUNT other generators, higher codes low.
// - Chopping applies after fault and current-limit overrides.
// - The carrier is offered as a module output for a pin.
// - A limit rising edge loads the primary time base into the capture register.
// - Capture uses the limit after blanking, so blanked edges never capture.
// - The secondary time base has no capture register.
// - Swap set routes high signal to low pin and low to high.
// - With sync set, swap changes only at cycle boundaries.
// - Swap sits before dead time, so swapped signals still get dead time.
// - Synchronised output changes take effect when the time base is zero.
module pbc_top
   import pbc_pkg::*;
#(
   parameter int TIMEBASE_WIDTH = 16,
   parameter int PEER_COUNT = 8
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Generator signals before post-processing.
   input wire logic gen_high_output,
   input wire logic gen_low_output,
   input wire logic [TIMEBASE_WIDTH-1:0] timebase_count,
   input wire logic [PEER_COUNT-1:0] peer_outputs,
   // Raw protection inputs from pins.
   input wire logic fault_in,
   input wire logic ilimit_in,
   // Override data already resolved by the fault and limit priority logic.
   input wire logic override_active_high,
   input wire logic override_active_low,
   input wire logic override_data_high,
   input wire logic override_data_low,
   // Blanking control.
   input wire logic blank_on_high_rise,
   input wire logic blank_on_high_fall,
   input wire logic blank_on_low_rise,
   input wire logic blank_on_low_fall,
   input wire logic fault_blank_enable,
   input wire logic ilimit_blank_enable,
   input wire logic state_blank_chopclk_high,
   input wire logic state_blank_chopclk_low,
   input wire logic state_blank_hi_out_high,
   input wire logic state_blank_hi_out_low,
   input wire logic state_blank_lo_out_high,
   input wire logic state_blank_lo_out_low,
   input wire logic state_blank_fault_enable,
   input wire logic state_blank_ilimit_enable,
   input wire logic [2:0] blank_source_select,
   input wire logic [11:0] blanking_delay_reg,
   // Chop control.
   input wire logic [15:0] carrier_divider_reg,
   input wire logic [2:0] pwm_clock_divide_select,
   input wire logic carrier_gate_high_enable,
   input wire logic carrier_gate_low_enable,
   input wire logic [3:0] carrier_source_select,
   // Output control.
   input wire logic [1:0] output_control_reg,
   // Results.
   output logic fault_blanked,
   output logic ilimit_blanked,
   output logic [TIMEBASE_WIDTH-1:0] timebase_capture_reg,
   output logic capture_event,
   output logic chop_clock_out,
   output logic dt_high_in,
   output logic dt_low_in,
   output logic blanking_active
);

   // Pin synchronisers: the first stage feeds only the second.
   logic fault_meta, fault_sync, ilimit_meta, ilimit_sync;
   logic [PEER_COUNT-1:0] peer_meta, peer_sync;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fault_meta <= 1'b0;
         fault_sync <= 1'b0;
         ilimit_meta <= 1'b0;
         ilimit_sync <= 1'b0;
         peer_meta <= '0;
         peer_sync <= '0;
      end else begin
         fault_meta <= fault_in;
         fault_sync <= fault_meta;
         ilimit_meta <= ilimit_in;
         ilimit_sync <= ilimit_meta;
         peer_meta <= peer_outputs;
         peer_sync <= peer_meta;
      end
   end

   // Select one peer generator by a code; code zero means none.
   function automatic logic pick_peer(input logic [3:0] code, input logic [PEER_COUNT-1:0] peers);
      logic result;
      result = 1'b0;
      for (int i = 1; i <= PEER_COUNT; i++) begin
         if (int'(code) == i) begin
            result = peers[i-1];
         end
      end
      return result;
   endfunction

   // Carrier generator and its source selection.
   pbc_carrier_if cif ();
   assign cif.enable = carrier_divider_reg[CARRIER_ENABLE_BIT];
   assign cif.ratio = carrier_divider_reg[CARRIER_RATIO_WIDTH-1:0];
   assign cif.prescale = pwm_clock_divide_select;
   pbc_carrier_gen u_carrier (
      .clk(clk),
      .nrst(nrst),
      .cif(cif)
   );
   logic carrier_sel;
   assign carrier_sel = (carrier_source_select == CARRIER_SRC_INTERNAL) ? cif.carrier
                        : pick_peer(carrier_source_select, peer_sync);

   // Output edge detection starts the blanking timer.
   logic high_prev, low_prev;
   logic [11:0] blank_count;
   logic [11:0] next_blank_count;
   logic edge_hit;
   always_comb begin
      edge_hit = (blank_on_high_rise & gen_high_output & ~high_prev)
               | (blank_on_high_fall & ~gen_high_output & high_prev)
               | (blank_on_low_rise & gen_low_output & ~low_prev)
               | (blank_on_low_fall & ~gen_low_output & low_prev);
      next_blank_count = blank_count;
      if (edge_hit) begin
         next_blank_count = blanking_delay_reg;
      end else if (blank_count != BLANK_COUNT_RESET) begin
         next_blank_count = blank_count - 12'h001;
      end
   end

   // State blanking from output levels, carrier and an optional peer source.
   logic state_blank;
   assign state_blank = (state_blank_hi_out_high & gen_high_output)
                      | (state_blank_hi_out_low & ~gen_high_output)
                      | (state_blank_lo_out_high & gen_low_output)
                      | (state_blank_lo_out_low & ~gen_low_output)
                      | (state_blank_chopclk_high & carrier_sel)
                      | (state_blank_chopclk_low & ~carrier_sel)
                      | pick_peer({1'b0, blank_source_select}, peer_sync);

   logic edge_blank;
   assign edge_blank = edge_hit ? (blanking_delay_reg != BLANK_COUNT_RESET)
                                : (blank_count != BLANK_COUNT_RESET);
   logic next_fault, next_ilimit;
   assign next_fault = fault_sync & ~(fault_blank_enable & edge_blank)
                       & ~(state_blank_fault_enable & state_blank);
   assign next_ilimit = ilimit_sync & ~(ilimit_blank_enable & edge_blank)
                        & ~(state_blank_ilimit_enable & state_blank);

   // Capture of the primary time base on a blanked limit rising edge.
   logic [TIMEBASE_WIDTH-1:0] next_capture;
   logic next_capture_event;
   always_comb begin
      next_capture_event = next_ilimit & ~ilimit_blanked;
      next_capture = next_capture_event ? timebase_count : timebase_capture_reg;
   end

   // Swap register: follows immediately unless sync holds it to time base zero.
   logic swap_state, next_swap;
   always_comb begin
      next_swap = swap_state;
      if (!output_control_reg[OUT_SYNC_BIT] || timebase_count == '0) begin
         next_swap = output_control_reg[OUT_SWAP_BIT];
      end
   end

   // Output path: override, then chop, then swap ahead of dead time.
   logic path_high, path_low, chop_high, chop_low;
   always_comb begin
      path_high = override_active_high ? override_data_high : gen_high_output;
      path_low = override_active_low ? override_data_low : gen_low_output;
      chop_high = carrier_gate_high_enable ? (path_high & carrier_sel) : path_high;
      chop_low = carrier_gate_low_enable ? (path_low & carrier_sel) : path_low;
   end

   // Registers for the block apart from the pin synchronisers and the carrier generator; every output comes from here.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         high_prev <= 1'b0;
         low_prev <= 1'b0;
         blank_count <= BLANK_COUNT_RESET;
         fault_blanked <= 1'b0;
         ilimit_blanked <= 1'b0;
         timebase_capture_reg <= '0;
         capture_event <= 1'b0;
         swap_state <= 1'b0;
         chop_clock_out <= 1'b0;
         dt_high_in <= 1'b0;
         dt_low_in <= 1'b0;
         blanking_active <= 1'b0;
      end else begin
         high_prev <= gen_high_output;
         low_prev <= gen_low_output;
         blank_count <= next_blank_count;
         fault_blanked <= next_fault;
         ilimit_blanked <= next_ilimit;
         timebase_capture_reg <= next_capture;
         capture_event <= next_capture_event;
         swap_state <= next_swap;
         chop_clock_out <= carrier_sel;
         dt_high_in <= swap_state ? chop_low : chop_high;
         dt_low_in <= swap_state ? chop_high : chop_low;
         blanking_active <= next_blank_count != BLANK_COUNT_RESET;
      end
   end

   // Assertions.
   sequence s_edge_loaded;
      edge_hit && blanking_delay_reg > 12'h001;
   endsequence
   a_blank_restart: assert property (@(posedge clk) disable iff (!nrst)
      s_edge_loaded |=> blank_count == $past(blanking_delay_reg))
      else $error("Blanking timer not reloaded on edge.");
   a_blank_countdown: assert property (@(posedge clk) disable iff (!nrst)
      !edge_hit && blank_count != 12'h000 |=> blank_count == $past(blank_count) - 12'h001)
      else $error("Blanking timer did not count down.");
   a_fault_masked: assert property (@(posedge clk) disable iff (!nrst)
      fault_blank_enable && blank_count != 12'h000 && !edge_hit |=> !fault_blanked)
      else $error("Fault passed during blanking.");
   a_ilimit_masked: assert property (@(posedge clk) disable iff (!nrst)
      ilimit_blank_enable && blank_count != 12'h000 && !edge_hit |=> !ilimit_blanked)
      else $error("Limit passed during blanking.");
   a_capture_load: assert property (@(posedge clk) disable iff (!nrst)
      $rose(ilimit_blanked) |-> timebase_capture_reg == $past(timebase_count))
      else $error("Capture missed limit edge.");
   a_capture_hold: assert property (@(posedge clk) disable iff (!nrst)
      !capture_event |-> $stable(timebase_capture_reg))
      else $error("Capture changed without edge.");
   a_swap_sync: assert property (@(posedge clk) disable iff (!nrst)
      output_control_reg[OUT_SYNC_BIT] && timebase_count != '0 |=> $stable(swap_state))
      else $error("Swap changed mid cycle.");
   a_swap_route: assert property (@(posedge clk) disable iff (!nrst)
      swap_state && !carrier_gate_high_enable && !override_active_high
      |=> dt_low_in == $past(gen_high_output))
      else $error("Swap route wrong.");
   a_chop_gate: assert property (@(posedge clk) disable iff (!nrst)
      carrier_gate_high_enable && !carrier_sel && !swap_state |=> !dt_high_in)
      else $error("Chop did not gate high output.");

   // A running timer that no edge reloads is the window in which limit edges must not capture.
   sequence s_blank_running;
      blank_count != 12'h000 && !edge_hit;
   endsequence
   a_blank_flag: assert property (@(posedge clk) disable iff (!nrst)
      blanking_active == (blank_count != 12'h000))
      else $error("Blanking flag disagrees with timer.");
   a_capture_masked: assert property (@(posedge clk) disable iff (!nrst)
      ilimit_blank_enable ##0 s_blank_running |=> !capture_event)
      else $error("Capture taken inside blanking window.");
   a_idle_stays: assert property (@(posedge clk) disable iff (!nrst)
      blank_count == 12'h000 && !edge_hit |=> blank_count == 12'h000)
      else $error("Timer started without a selected edge.");
   a_edge_mask_now: assert property (@(posedge clk) disable iff (!nrst)
      edge_hit && blanking_delay_reg != 12'h000 && fault_blank_enable
      |=> !fault_blanked)
      else $error("Fault passed on the blanking edge.");

   // State blanking has no timer, so it must mask in the very next registered value.
   a_state_fault: assert property (@(posedge clk) disable iff (!nrst)
      state_blank && state_blank_fault_enable |=> !fault_blanked)
      else $error("Fault passed during state blanking.");
   a_state_limit: assert property (@(posedge clk) disable iff (!nrst)
      state_blank && state_blank_ilimit_enable |=> !ilimit_blanked)
      else $error("Limit passed during state blanking.");
   a_peer_blank: assert property (@(posedge clk) disable iff (!nrst)
      blank_source_select == 3'h1 && peer_sync[0] && state_blank_ilimit_enable
      |=> !ilimit_blanked)
      else $error("Peer source did not blank the limit.");

   // Output routing and carrier selection seen from the registered outputs.
   a_swap_load: assert property (@(posedge clk) disable iff (!nrst)
      output_control_reg[OUT_SYNC_BIT] && timebase_count == '0
      |=> swap_state == $past(output_control_reg[OUT_SWAP_BIT]))
      else $error("Swap not loaded at time base zero.");
   a_straight_route: assert property (@(posedge clk) disable iff (!nrst)
      !swap_state && !carrier_gate_low_enable && !override_active_low
      |=> dt_low_in == $past(gen_low_output))
      else $error("Unswapped low route wrong.");
   a_carrier_out: assert property (@(posedge clk) disable iff (!nrst)
      carrier_source_select == CARRIER_SRC_INTERNAL
      |=> chop_clock_out == $past(cif.carrier))
      else $error("Carrier output not from the internal generator.");
   a_chop_low_gate: assert property (@(posedge clk) disable iff (!nrst)
      carrier_gate_low_enable && !carrier_sel && !swap_state |=> !dt_low_in)
      else $error("Chop did not gate low output.");

endmodule

// file: bench/tb.sv
`timescale 1ns/1ps
module tb;
   import pbc_pkg::*;

   // Bench copies of the design ports; inputs other than clk are driven from the main sequence.
   logic clk, nrst, gh, gl, flt, lim, oah, oal, odh, odl, fbe, lbe, sfe, sle, cgh, cgl;
   logic [3:0] es, csel;
   logic [5:0] sb;
   logic [2:0] bsel, pdiv;
   logic [11:0] dly;
   logic [15:0] tbc, cdiv, capv;
   logic [7:0] peer;
   logic [1:0] ocr;
   logic fb, lb, cap, chop, dth, dtl, bact;
   int n_errors = 0;
   int total_checks = 0;
   int n_blank = 0, n_cap = 0, n_fhi = 0, n_tog = 0, ncyc = 0, t_prev = 0, t_last = 0;
   logic chop_q = 1'b0;
   // Chop ratio, prescale and the expected half period in clock cycles.
   logic [9:0] rat [3] = '{10'h002, 10'h000, 10'h003};
   logic [2:0] pre [3] = '{3'h1, 3'h0, 3'h2};
   int per [3] = '{6, 1, 16};

   pbc_top u_pbc_top (
      .clk(clk), .nrst(nrst), .gen_high_output(gh), .gen_low_output(gl),
      .timebase_count(tbc), .peer_outputs(peer), .fault_in(flt), .ilimit_in(lim),
      .override_active_high(oah), .override_active_low(oal),
      .override_data_high(odh), .override_data_low(odl),
      .blank_on_high_rise(es[0]), .blank_on_high_fall(es[1]),
      .blank_on_low_rise(es[2]), .blank_on_low_fall(es[3]),
      .fault_blank_enable(fbe), .ilimit_blank_enable(lbe),
      .state_blank_hi_out_high(sb[0]), .state_blank_hi_out_low(sb[1]),
      .state_blank_lo_out_high(sb[2]), .state_blank_lo_out_low(sb[3]),
      .state_blank_chopclk_high(sb[4]), .state_blank_chopclk_low(sb[5]),
      .state_blank_fault_enable(sfe), .state_blank_ilimit_enable(sle),
      .blank_source_select(bsel), .blanking_delay_reg(dly), .carrier_divider_reg(cdiv),
      .pwm_clock_divide_select(pdiv), .carrier_gate_high_enable(cgh),
      .carrier_gate_low_enable(cgl), .carrier_source_select(csel),
      .output_control_reg(ocr), .fault_blanked(fb), .ilimit_blanked(lb),
      .timebase_capture_reg(capv), .capture_event(cap), .chop_clock_out(chop),
      .dt_high_in(dth), .dt_low_in(dtl), .blanking_active(bact)
   );

   // Free-running 40 MHz clock.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Tallies are taken mid-cycle, so registered outputs have settled and no race arises.
   always @(negedge clk) begin
      ncyc++;
      if (bact === 1'b1) n_blank++;
      if (cap === 1'b1) n_cap++;
      if (fb === 1'b1) n_fhi++;
      if (chop !== chop_q) begin
         n_tog++;
         t_prev = t_last;
         t_last = ncyc;
      end
      chop_q = chop;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // One or two high-output edges; the active time is counted across both.
   task automatic blank_len(input logic [11:0] d, input int gap, input logic [31:0] exp);
      int b0;
      dly <= d;
      es <= 4'h3;
      cyc(2);
      b0 = n_blank;
      gh <= ~gh;
      if (gap > 0) begin
         cyc(gap);
         gh <= ~gh;
      end
      cyc(d + gap + 6);
      chk(n_blank - b0, exp);
   endtask

   // Protection pulses inside a long window; the limit drops before the window ends.
   task automatic fault_case(input logic en);
      int f0, c0;
      {fbe, lbe} <= {en, en};
      es <= 4'h1;
      dly <= 12'h01e;
      cyc(2);
      gh <= 1'b1;
      cyc(2);
      f0 = n_fhi;
      c0 = n_cap;
      {flt, lim} <= 2'b11;
      cyc(8);
      {flt, lim} <= 2'b00;
      cyc(3);
      chk(n_fhi - f0 > 0, !en);
      chk(n_cap - c0 > 0, !en);
      es <= 4'h0;
      gh <= 1'b0;
      cyc(40);
   endtask

   initial begin
      int b0;
      {gh, gl, flt, lim, oah, oal, odh, odl, fbe, lbe, sfe, sle, cgh, cgl} = '0;
      {es, csel, sb, bsel, pdiv, dly, tbc, cdiv, peer, ocr} = '0;
      nrst = 1'b0;
      cyc(5);
      chk({fb, lb, cap, chop, dth, dtl, bact, capv}, 0);
      nrst <= 1'b1;
      cyc(2);
      blank_len(12'h003, 0, 3);
      blank_len(12'h000, 0, 0);
      blank_len(12'hfff, 0, 4095);
      blank_len(12'h00a, 4, 14);
      $display("test blank_length done");
      es <= 4'h0;
      dly <= 12'h005;
      {gh, gl} <= 2'b00;
      cyc(3);
      // Every select against every edge: only the matching edge may start the timer.
      for (int i = 0; i < 4; i++) begin
         es <= 4'h1 << i;
         cyc(2);
         for (int j = 0; j < 4; j++) begin
            b0 = n_blank;
            if (j < 2) gh <= ~gh;
            else gl <= ~gl;
            cyc(10);
            chk(n_blank - b0, (i == j) ? 5 : 0);
         end
      end
      $display("test edge_select done");
      es <= 4'h0;
      cyc(8);
      fault_case(1'b1);
      fault_case(1'b0);
      $display("test fault_mask done");
      tbc <= 16'h0123;
      cyc(3);
      b0 = n_cap;
      lim <= 1'b1;
      cyc(8);
      chk(n_cap - b0, 1);
      chk(capv, 16'h0123);
      lim <= 1'b0;
      cyc(6);
      chk(capv, 16'h0123);
      $display("test capture done");
      // The carrier is stopped here, so its state bits see a steady low level.
      sle <= 1'b1;
      {flt, lim} <= 2'b11;
      for (int k = 0; k < 6; k++) begin
         sb <= 6'h01 << k;
         {gh, gl} <= {~k[0], ~k[0]};
         cyc(6);
         chk(lb, k == 4);
         chk(fb, 1'b1);
         if (k < 4) begin
            {gh, gl} <= {k[0], k[0]};
            cyc(4);
            chk(lb, 1'b1);
         end
      end
      sfe <= 1'b1;
      cyc(6);
      chk(fb, 1'b0);
      {sb, sfe} <= 7'h00;
      bsel <= 3'h3;
      peer <= 8'h04;
      cyc(6);
      chk(lb, 1'b0);
      peer <= 8'h00;
      cyc(6);
      chk(lb, 1'b1);
      {bsel, sle, flt, lim} <= 6'h00;
      cyc(6);
      $display("test state_blank done");
      for (int i = 0; i < 3; i++) begin
         cdiv <= {1'b1, 5'h00, rat[i]};
         pdiv <= pre[i];
         cyc(80);
         chk(t_last - t_prev, per[i]);
      end
      cdiv <= 16'h0003;
      cyc(6);
      b0 = n_tog;
      cyc(40);
      chk(n_tog - b0, 0);
      chk(chop, 1'b0);
      $display("test carrier done");
      {gh, gl, cgh, cgl} <= 4'b1110;
      cyc(3);
      chk({dth, dtl}, 2'b01);
      csel <= 4'h1;
      peer <= 8'h01;
      cyc(6);
      chk({dth, dtl, chop}, 3'b111);
      {oah, odh, oal, odl, gh} <= 5'b11110;
      cyc(3);
      chk({dth, dtl}, 2'b11);
      peer <= 8'h00;
      cyc(6);
      chk({dth, dtl, chop}, 3'b010);
      csel <= 4'h9;
      peer <= 8'hff;
      cyc(6);
      chk(chop, 1'b0);
      {oah, oal, cgh, cgl, csel} <= 8'h00;
      $display("test chop done");
      {gh, gl} <= 2'b10;
      tbc <= 16'h0005;
      ocr <= 2'b10;
      cyc(4);
      chk({dth, dtl}, 2'b01);
      ocr <= 2'b00;
      cyc(4);
      chk({dth, dtl}, 2'b10);
      ocr <= 2'b11;
      cyc(4);
      chk({dth, dtl}, 2'b10);
      tbc <= 16'h0000;
      cyc(1);
      tbc <= 16'h0005;
      cyc(3);
      chk({dth, dtl}, 2'b01);
      $display("test swap done");
      wrap_up();
   end
endmodule
